// File: include/wdt_pkg.sv
package wdt_pkg;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] RANGE_OFFSET = 8'h04;
  localparam logic [7:0] RSTLEN_OFFSET = 8'h08;
  localparam logic [7:0] RESTART_OFFSET = 8'h0C;
  localparam logic [7:0] COUNT_OFFSET = 8'h10;
  localparam logic [7:0] STATUS_OFFSET = 8'h14;
  localparam logic [7:0] MASK_OFFSET = 8'h18;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam int EV_TIMEOUT_BIT = 0;
  localparam int EV_RESET_BIT = 1;
  localparam int STATUS_WIDTH = 2;

  localparam logic [31:0] RESTART_KEY = 32'h00000076;
  localparam logic [3:0] RANGE_RESET = 4'hF;
  localparam logic [7:0] RSTLEN_RESET = 8'h10;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int RANGE_BASE_LOG2 = 16;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef struct packed {
    logic enable;
    logic irq_first;
  } ctrl_s;

  typedef enum logic [1:0] {RUN, WARNED, RESETTING} wdt_state_e;
endpackage

// File: logic/watchdog_timer.sv
`timescale 1ns/10ps
module watchdog_timer (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic IRQ,
  output logic SYS_RESET_N
);
  wdt_pkg::bus_req_s req;
  wdt_pkg::ctrl_s ctrl_q;
  wdt_pkg::wdt_state_e state_q;
  logic [3:0] range_q;
  logic [7:0] rstlen_q;
  logic [31:0] count_q;
  logic [1:0] status_q;
  logic [1:0] mask_q;
  logic [31:0] rdata_q;
  logic irq_q;
  logic sysrst_n_q;
  logic [31:0] preset;
  logic restart;
  logic timeout;
  logic fire_reset;
  logic pulse_active;
  logic [1:0] events;
  logic status_rd;

  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  function automatic logic hit(input wdt_pkg::bus_req_s r,
                               input logic [7:0] off);
    hit = (r.addr == off);
  endfunction

  assign restart = req.wr && hit(req, wdt_pkg::RESTART_OFFSET)
    && req.wdata == wdt_pkg::RESTART_KEY;
  assign status_rd = req.rd && hit(req, wdt_pkg::STATUS_OFFSET);

  wdt_preset u_preset (
    .range_sel(range_q),
    .preset(preset)
  );

  // Control registers
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      ctrl_q <= wdt_pkg::CTRL_RESET;
      range_q <= wdt_pkg::RANGE_RESET;
      rstlen_q <= wdt_pkg::RSTLEN_RESET;
      mask_q <= wdt_pkg::MASK_RESET;
    end
    else if (req.wr)
    begin
      // Enable is sticky: a runaway program cannot switch the dog off
      if (hit(req, wdt_pkg::CTRL_OFFSET))
      begin
        ctrl_q.enable <= ctrl_q.enable | req.wdata[wdt_pkg::CTRL_EN_BIT];
        ctrl_q.irq_first <= req.wdata[wdt_pkg::CTRL_MODE_BIT];
      end
      if (hit(req, wdt_pkg::RANGE_OFFSET))
        range_q <= req.wdata[3:0];
      if (hit(req, wdt_pkg::RSTLEN_OFFSET))
        rstlen_q <= req.wdata[7:0];
      if (hit(req, wdt_pkg::MASK_OFFSET))
        mask_q <= req.wdata[1:0];
    end
  end

  // Counter on the bus clock
  assign timeout = ctrl_q.enable && count_q == 32'h00000000
    && state_q != wdt_pkg::RESETTING;
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
      count_q <= 32'hFFFFFFFF;
    else if (!ctrl_q.enable || restart || timeout)
      count_q <= preset;
    else if (state_q != wdt_pkg::RESETTING)
      count_q <= count_q - 32'h00000001;
  end

  // Response sequencing
  // Warned state stays until the status read clears the interrupt or a second timeout fires the reset
  always_comb
  begin
    fire_reset = 1'b0;
    if (timeout)
    begin
      if (!ctrl_q.irq_first)
        fire_reset = 1'b1;
      else if (state_q == wdt_pkg::WARNED)
        fire_reset = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
      state_q <= wdt_pkg::RUN;
    else
    begin
      unique case (state_q)
        wdt_pkg::RUN:
          if (fire_reset)
            state_q <= wdt_pkg::RESETTING;
          else if (timeout)
            state_q <= wdt_pkg::WARNED;
        wdt_pkg::WARNED:
          if (fire_reset)
            state_q <= wdt_pkg::RESETTING;
          else if (status_rd)
            state_q <= wdt_pkg::RUN;
        wdt_pkg::RESETTING:
          if (!pulse_active)
            state_q <= wdt_pkg::RUN;
      endcase
    end
  end

  wdt_reset_pulse u_pulse (
    .clk(REF_CLK),
    .rst_n(RESET_N),
    .start(fire_reset),
    .length(rstlen_q),
    .active(pulse_active)
  );

  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
      sysrst_n_q <= 1'b1;
    else
      sysrst_n_q <= !pulse_active;
  end

  // Sticky status; a new event beats the read clear
  always_comb
  begin
    events = 2'h0;
    events[wdt_pkg::EV_TIMEOUT_BIT] = timeout && ctrl_q.irq_first
      && !fire_reset;
    events[wdt_pkg::EV_RESET_BIT] = fire_reset;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
      status_q <= 2'h0;
    else if (status_rd)
      status_q <= events;
    else
      status_q <= status_q | events;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
      irq_q <= 1'b0;
    else
      irq_q <= |(status_q & mask_q);
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
      rdata_q <= 32'h00000000;
    else if (req.rd)
    begin
      unique case (req.addr)
        wdt_pkg::CTRL_OFFSET:
          rdata_q <= {30'h00000000, ctrl_q.irq_first, ctrl_q.enable};
        wdt_pkg::RANGE_OFFSET:
          rdata_q <= {28'h0000000, range_q};
        wdt_pkg::RSTLEN_OFFSET:
          rdata_q <= {24'h000000, rstlen_q};
        wdt_pkg::COUNT_OFFSET:
          rdata_q <= count_q;
        wdt_pkg::STATUS_OFFSET:
          rdata_q <= {30'h00000000, status_q};
        wdt_pkg::MASK_OFFSET:
          rdata_q <= {30'h00000000, mask_q};
        default:
          rdata_q <= 32'h00000000;
      endcase
    end
    else
      rdata_q <= 32'h00000000;
  end

  assign RDATA = rdata_q;
  assign IRQ = irq_q;
  assign SYS_RESET_N = sysrst_n_q;
endmodule

// File: logic/wdt_preset.sv
`timescale 1ns/10ps
module wdt_preset (
  input wire logic [3:0] range_sel,
  output logic [31:0] preset
);
  // Sixteen ranges, each a doubling of the last
  always_comb
  begin
    preset = (32'h00000001 << (wdt_pkg::RANGE_BASE_LOG2
      + int'(range_sel))) - 32'h00000001;
  end
endmodule

// File: logic/wdt_reset_pulse.sv
`timescale 1ns/10ps
module wdt_reset_pulse (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [7:0] length,
  output logic active
);
  logic [7:0] left_q;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      left_q <= 8'h00;
    else if (start && left_q == 8'h00)
      left_q <= (length == 8'h00) ? 8'h01 : length;
    else if (left_q != 8'h00)
      left_q <= left_q - 8'h01;
  end
  assign active = (left_q != 8'h00);
endmodule

// File: testbench/test_watchdog_timer.sv
`timescale 1ns/10ps
`define CHK(n, e, s) \
  checks++; \
  if ((s) !== (e)) \
  begin \
    n_mismatch++; \
    $display("BAD %s exp %h got %h", n, e, s); \
  end
module test_watchdog_timer;
  logic REF_CLK = 1'h0;
  logic RESET_N = 1'h0;
  logic [7:0] ADDR = 8'h0;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'h0;
  logic RD = 1'h0;
  logic [31:0] RDATA;
  logic IRQ;
  logic SYS_RESET_N;
  logic [31:0] q;
  int n_mismatch = 0;
  int checks = 0;
  watchdog_timer dut (.REF_CLK, .RESET_N, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .IRQ, .SYS_RESET_N);
  initial
  begin
    forever #2 REF_CLK = ~REF_CLK;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'h1;
    @(posedge REF_CLK);
    WR <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    ADDR <= a;
    RD <= 1'h1;
    @(posedge REF_CLK);
    RD <= 1'h0;
    @(negedge REF_CLK);
    q = RDATA;
    @(posedge REF_CLK);
  endtask
  task t_reset;
    `CHK("sysrst", 1'h1, SYS_RESET_N)
    rd(wdt_pkg::CTRL_OFFSET);
    `CHK("ctrl", 32'h0, q)
    rd(wdt_pkg::RANGE_OFFSET);
    `CHK("range", 32'hF, q)
    rd(wdt_pkg::RSTLEN_OFFSET);
    `CHK("rstlen", 32'h10, q)
    rd(wdt_pkg::COUNT_OFFSET);
    `CHK("count", 32'h7FFFFFFF, q)
    rd(8'h20);
    `CHK("unmapped", 32'h0, q)
    $display("reset values done");
  endtask
  task t_range;
    wr(wdt_pkg::RANGE_OFFSET, 32'h0);
    rd(wdt_pkg::RANGE_OFFSET);
    `CHK("range", 32'h0, q)
    rd(wdt_pkg::COUNT_OFFSET);
    `CHK("preset", 32'hFFFF, q)
    wr(wdt_pkg::RSTLEN_OFFSET, 32'h3);
    rd(wdt_pkg::RSTLEN_OFFSET);
    `CHK("rstlen", 32'h3, q)
    $display("range done");
  endtask
  task t_enable;
    wr(wdt_pkg::CTRL_OFFSET, 32'h3);
    @(posedge REF_CLK);
    // Enable bit written low, mode kept: enable must stay set
    wr(wdt_pkg::CTRL_OFFSET, 32'h2);
    rd(wdt_pkg::CTRL_OFFSET);
    `CHK("ctrl", 32'h3, q)
    // Back to back reads: one cycle apart, so exactly one step down
    ADDR <= wdt_pkg::COUNT_OFFSET;
    RD <= 1'h1;
    @(posedge REF_CLK);
    @(negedge REF_CLK);
    q = RDATA;
    @(posedge REF_CLK);
    RD <= 1'h0;
    @(negedge REF_CLK);
    `CHK("step", q - 32'h1, RDATA)
    @(posedge REF_CLK);
    wr(wdt_pkg::RESTART_OFFSET, wdt_pkg::RESTART_KEY);
    rd(wdt_pkg::COUNT_OFFSET);
    `CHK("reload", 1'h1, q > 32'hFFF0)
    $display("enable done");
  endtask
  task t_warn;
    // Past one timeout, well short of a second one
    repeat (66000) @(posedge REF_CLK);
    `CHK("masked", 1'h0, IRQ)
    wr(wdt_pkg::MASK_OFFSET, 32'h1);
    repeat (2) @(negedge REF_CLK);
    `CHK("irq", 1'h1, IRQ)
    @(posedge REF_CLK);
    rd(wdt_pkg::STATUS_OFFSET);
    `CHK("status", 32'h1, q)
    repeat (2) @(negedge REF_CLK);
    `CHK("cleared", 1'h0, IRQ)
    `CHK("no reset", 1'h1, SYS_RESET_N)
    @(posedge REF_CLK);
    rd(wdt_pkg::STATUS_OFFSET);
    `CHK("status", 32'h0, q)
    $display("warning done");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge REF_CLK);
    RESET_N <= 1'h1;
    @(posedge REF_CLK);
    t_reset;
    t_range;
    t_enable;
    t_warn;
    tally_and_finish;
  end
endmodule

// File: testbench/wdt_sva.sv
`timescale 1ns/10ps
module wdt_sva (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic IRQ,
  input wire logic SYS_RESET_N
);
  logic [1:0] mask_q;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  // Mirror of the mask, so a masked event can be told apart
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
      mask_q <= 2'h0;
    else if (WR && ADDR == wdt_pkg::MASK_OFFSET)
      mask_q <= WDATA[1:0];
  end
  sequence rd_cnt;
    RD && ADDR == wdt_pkg::COUNT_OFFSET;
  endsequence
  sequence rng_wr_rd;
    WR && ADDR == wdt_pkg::RANGE_OFFSET ##1
      RD && ADDR == wdt_pkg::RANGE_OFFSET;
  endsequence
  chk_rdata_idle: assert property (!RD |=> RDATA == 32'h0)
    else $error("read data not zero when idle");
  chk_unmapped_zero: assert property (RD && ADDR == 8'h20 |=> RDATA == 32'h0)
    else $error("unmapped read not zero");
  chk_reset_outputs: assert property (
    $rose(RESET_N) |-> !IRQ && SYS_RESET_N && RDATA == 32'h0)
    else $error("outputs wrong after reset");
  chk_count_down: assert property (
    rd_cnt ##1 rd_cnt |=> RDATA + 32'h1 == $past(RDATA) ||
      RDATA == $past(RDATA) || $past(RDATA) == 32'h0)
    else $error("counter did not step down");
  chk_range_back: assert property (
    rng_wr_rd |=> RDATA == {28'h0, $past(WDATA[3:0], 2)})
    else $error("range selector readback wrong");
  chk_irq_masked: assert property (
    mask_q == 2'h0 [*3] |-> !IRQ)
    else $error("masked interrupt reached output");
  chk_irq_cleared: assert property (
    RD && ADDR == wdt_pkg::STATUS_OFFSET && IRQ |-> ##[1:3] !IRQ)
    else $error("interrupt not cleared by status read");
  chk_pulse_ends: assert property (
    $fell(SYS_RESET_N) |-> ##[1:257] SYS_RESET_N)
    else $error("system reset pulse too long");
endmodule
bind watchdog_timer wdt_sva sva (.REF_CLK, .RESET_N, .ADDR, .WDATA, .WR,
  .RD, .RDATA, .IRQ, .SYS_RESET_N);
